// ### common/sdrcfg_pkg.sv
// Purpose: Shared constants and types for the SDRAM status/configuration register bank
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses within the bank
package sdrcfg_pkg;

    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_CONFIG = 12'h008;

    // Status register field
    localparam int BIT_DLL_READY = 2;

    // Configuration register fields
    localparam int BIT_BANK_POS     = 26;
    localparam int BIT_MOBILE_EN    = 25;
    localparam int BIT_DRIVE_HI     = 24;
    localparam int BIT_UNLOCK       = 23;
    localparam int BIT_DIFF_STROBE  = 22;
    localparam int BIT_DDR2_EN      = 20;
    localparam int BIT_DRIVE_LO     = 18;
    localparam int BIT_DDR_EN       = 17;
    localparam int BIT_SDRAM_EN     = 16;
    localparam int BIT_TIM_UNLOCK   = 15;
    localparam int BIT_NARROW       = 14;
    localparam int POS_CAS          = 9;
    localparam int POS_INTERNAL_BANK_COUNT        = 4;
    localparam int POS_PAGE         = 0;

    // Writable bits; everything else is reserved and reads zero
    localparam logic [31:0] CFG_RW_MASK    = 32'h07d7_ce77;
    // Bits that only change while the unlock bit holds 1
    localparam logic [31:0] CFG_PROT_MASK  = 32'h0357_0000;
    // Bits whose change starts memory initialization
    localparam logic [31:0] CFG_INIT_MASK  = 32'h0104_0e77;
    localparam logic [31:0] CFG_RESET      = 32'h0013_4a20;

    typedef struct packed {
        logic       bank_position_select;
        logic       mobile_memory_enable;
        logic [1:0] drive_strength;
        logic       differential_strobe_select;
        logic       second_gen_enable;
        logic       double_rate_enable;
        logic       sync_dram_enable;
        logic       timing_write_unlock;
        logic       narrow_bus_select;
        logic [2:0] cas_latency;
        logic [2:0] internal_bank_count;
        logic [2:0] column_page_size;
    } sdrcfg_fields_s;

endpackage

// ### verif/sdrcfg_regs_bench.sv
// Purpose: Self-checking bench for the SDRAM register bank
// Assumes: Answer within 20 cycles
// Notes:   cur holds the expected stored configuration word
`timescale 1ns/1ps
module sdrcfg_regs_bench;
    logic        clk, nrst, psel, pen, pwr, pw, rs, lk, prdy, perr, ist, ini, err;
    logic [11:0] addr;
    logic [31:0] wd, prd, rd, cur;
    int          fail_count, compares;
    sdrcfg_regs u_sdrcfg_regs (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_dll_powered(pw),
        .i_dll_in_reset(rs), .i_dll_locked(lk), .o_cfg(), .o_init_start(ist));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task tally_and_finish;
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        rd = prd;
        err = perr;
        ini = ist;
        psel <= 1'b0;
        pen <= 1'b0;
        if (prdy !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: no pready", $time);
            tally_and_finish();
        end
    endtask
    // Expected word: locked writes keep the protected bits
    task wr(input logic [31:0] d);
        logic [31:0] exp;
        exp = (cur[23] ? d : (d & ~sdrcfg_pkg::CFG_PROT_MASK) | (cur & sdrcfg_pkg::CFG_PROT_MASK));
        exp = exp & sdrcfg_pkg::CFG_RW_MASK;
        apb(1'b1, sdrcfg_pkg::OFS_CONFIG, d);
        chk({31'h0, ini}, {31'h0, |((exp ^ cur) & sdrcfg_pkg::CFG_INIT_MASK)});
        apb(1'b0, sdrcfg_pkg::OFS_CONFIG, 32'h0);
        chk(rd, exp);
        cur = exp;
    endtask
    task dll(input logic [2:0] v);
        @(posedge clk);
        {pw, rs, lk} <= v;
        repeat (3) @(posedge clk);
        apb(1'b0, sdrcfg_pkg::OFS_STATUS, 32'h0);
        chk(rd, {29'h0, v == 3'b101, 2'b00});
    endtask
    initial begin
        {nrst, psel, pen, pwr, pw, rs, lk} = 7'h00;
        addr = 12'h000;
        wd = 32'h0;
        fail_count = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        cur = sdrcfg_pkg::CFG_RESET;
        apb(1'b0, sdrcfg_pkg::OFS_CONFIG, 32'h0);
        chk(rd, sdrcfg_pkg::CFG_RESET);
        for (int i = 0; i < 8; i++) dll(i[2:0]);
        dll(3'b101);
        apb(1'b1, sdrcfg_pkg::OFS_STATUS, 32'h0000_0004);
        apb(1'b0, sdrcfg_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_0004);
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(32'h07c4_c457);
        wr(32'h0255_4e20);
        wr(32'h0000_4e20);
        for (int k = 0; k < 4; k++) begin
            wr(cur | 32'h0080_0000);
            wr((cur & ~32'h0184_0000) | {7'h0, k[1], 5'h0, k[0], 18'h0});
        end
        wr(cur ^ 32'h0400_8200);
        tally_and_finish();
    end
endmodule

// ### verif/sdrcfg_regs_props.sv
// Purpose: Assertions on the SDRAM register bank ports
// Assumes: Master holds requests until pready; DLL levels steady around reads
// Notes:   unlk mirrors the stored unlock bit from observed writes
`timescale 1ns/1ps
module sdrcfg_regs_props (
    input wire logic                  i_sys_clk,
    input wire logic                  i_nrst,
    input wire logic                  i_psel,
    input wire logic                  i_penable,
    input wire logic                  i_pwrite,
    input wire logic [11:0]           i_paddr,
    input wire logic [31:0]           i_pwdata,
    input wire logic [31:0]           o_prdata,
    input wire logic                  o_pready,
    input wire logic                  o_pslverr,
    input wire logic                  i_dll_powered,
    input wire logic                  i_dll_in_reset,
    input wire logic                  i_dll_locked,
    input wire sdrcfg_pkg::sdrcfg_fields_s o_cfg,
    input wire logic                  o_init_start
);
    logic        unlk;
    logic        cfg_wr;
    logic        rd_ok;
    logic        dllv;
    logic [6:0]  prot;
    logic [11:0] open_f;
    logic [10:0] initv;
    assign cfg_wr = i_psel && i_penable && !o_pready && i_pwrite && i_paddr == sdrcfg_pkg::OFS_CONFIG;
    assign rd_ok  = o_pready && !i_pwrite;
    assign dllv   = i_dll_powered && !i_dll_in_reset && i_dll_locked;
    assign prot   = {o_cfg[17:15], o_cfg[14:12], o_cfg[11]};
    assign open_f = {o_cfg[18], o_cfg[10:0]};
    assign initv  = {o_cfg[16:15], o_cfg[8:0]};
    // Stored unlock bit, needed to judge protected updates
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) unlk <= 1'b0;
        else if (cfg_wr) unlk <= i_pwdata[23];
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_cfg_wr;
        cfg_wr;
    endsequence
    chk_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
    chk_ready_answer: assert property ($rose(i_psel && i_penable) |=> o_pready) else $error("pready late");
    chk_dll_status: assert property (rd_ok && i_paddr == sdrcfg_pkg::OFS_STATUS |->
        o_prdata == {29'h0, $past(dllv, 2), 2'b00}) else $error("status word wrong");
    chk_cfg_rsvd: assert property (rd_ok && i_paddr == sdrcfg_pkg::OFS_CONFIG |->
        (o_prdata & ~sdrcfg_pkg::CFG_RW_MASK) == 32'h0) else $error("reserved bit set");
    chk_prot_gate: assert property ($changed(prot) && $past(i_nrst, 2) |-> $past(unlk))
        else $error("protected bit changed while locked");
    chk_prot_write: assert property (s_cfg_wr ##0 unlk |=> prot == $past({i_pwdata[25:24], i_pwdata[18],
        i_pwdata[22], i_pwdata[20], i_pwdata[17:16]})) else $error("protected write lost");
    chk_open_write: assert property (s_cfg_wr |=> open_f == $past({i_pwdata[26], i_pwdata[15:14],
        i_pwdata[11:9], i_pwdata[6:4], i_pwdata[2:0]})) else $error("field write lost");
    chk_init_pulse: assert property ($past(i_nrst, 2) |-> o_init_start == $changed(initv))
        else $error("init launch mismatch");
    chk_err_reply: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("bad error reply");
endmodule
bind sdrcfg_regs sdrcfg_regs_props u_sdrcfg_regs_props (.*);

// ### verilog/sdrcfg_dll_status.sv
// Purpose: Registered DLL ready indication
// Assumes: DLL level inputs synchronous to i_sys_clk
// Notes:   Ready only when powered, out of reset and locked
`timescale 1ns/1ps
module sdrcfg_dll_status (
    input  wire logic i_sys_clk,
    input  wire logic i_nrst,
    input  wire logic i_dll_powered,
    input  wire logic i_dll_in_reset,
    input  wire logic i_dll_locked,
    output logic      o_dll_ready
);
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_dll_ready <= 1'b0;
        end else begin
            o_dll_ready <= i_dll_powered & ~i_dll_in_reset & i_dll_locked;
        end
    end
endmodule

// ### verilog/sdrcfg_regs.sv
// Purpose: SDRAM status and configuration registers behind an APB slave
// Assumes: Single clock, synchronous active-low reset, DLL levels synchronous
// Notes:   Init request is a one-cycle pulse; the sequence itself lives elsewhere
//
// Contract
// - The DLL ready status bit 2 reads 1 only while the DLL is powered, out of reset and locked.
// - A write changing drive strength, CAS latency, bank count or page size launches memory initialization.
// - Bank position bit 26 selects normal (0) or special partial-self-refresh (1) address mapping.
// - Mobile enable bit 25 enables mobile memory operation when 1.
// - Unlock bit 23 gates writes to drive strength and the four memory-type enables; they change only while it holds 1.
// - Strobe select bit 22 chooses single-ended (0) or differential (1) strobes and is writable only while unlocked.
// - DDR2 enable bit 20 enables DDR2 operation when 1.
// - Bit 24 is the upper bit of the two-bit drive strength field, whose lower bit is bit 18.
// - Drive strength encodes memory output impedance: DDR2 normal/weak, mobile full/half/quarter/eighth.
// - Timing unlock bit 15 permits changes to the timing registers when 1 and blocks them when 0.
`timescale 1ns/1ps
module sdrcfg_regs (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_nrst,
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [11:0]                 i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    input  wire logic                        i_dll_powered,
    input  wire logic                        i_dll_in_reset,
    input  wire logic                        i_dll_locked,
    output sdrcfg_pkg::sdrcfg_fields_s       o_cfg,
    output logic                             o_init_start
);

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_DONE = 1'b1
    } sdrcfg_bus_e;

    sdrcfg_bus_e  state;
    logic [31:0]  cfg;
    logic [31:0]  next_cfg;
    logic         dll_ready;
    logic         access;
    logic         wr_cfg;
    logic         hit;
    // Value the register holds after this edge, so o_cfg matches cfg cycle for cycle outside reset, where o_cfg clears to zero
    logic [31:0]  cfg_now;

    // Address decode for the error reply; the read mux compares the offsets itself.
    // Only the two mapped words answer without an error; every other
    // offset in the 4 KiB window gets pslverr and reads as zero.
    // Writes to the status word are dropped silently, since it has
    // no storage of its own behind it.
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == sdrcfg_pkg::OFS_STATUS) || (a == sdrcfg_pkg::OFS_CONFIG);
    endfunction

    sdrcfg_dll_status u_dll (
        .i_sys_clk      (i_sys_clk),
        .i_nrst         (i_nrst),
        .i_dll_powered  (i_dll_powered),
        .i_dll_in_reset (i_dll_in_reset),
        .i_dll_locked   (i_dll_locked),
        .o_dll_ready    (dll_ready)
    );

    // Access phase answered once; one wait state keeps pready registered
    assign access = i_psel & i_penable & (state == ST_IDLE);
    assign hit    = addr_hit(i_paddr);
    assign wr_cfg = access & i_pwrite & (i_paddr == sdrcfg_pkg::OFS_CONFIG);
    assign cfg_now = wr_cfg ? next_cfg : cfg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (access) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Protected bits follow the write only while the stored unlock bit is 1
    always_comb begin
        logic [31:0] keep;
        keep = sdrcfg_pkg::CFG_PROT_MASK | (32'h1 << sdrcfg_pkg::BIT_DIFF_STROBE);
        if (cfg[sdrcfg_pkg::BIT_UNLOCK]) begin
            keep = 32'h0000_0000;
        end
        next_cfg = ((i_pwdata & ~keep) | (cfg & keep)) & sdrcfg_pkg::CFG_RW_MASK;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            cfg <= sdrcfg_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg <= next_cfg;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_init_start <= 1'b0;
        end else begin
            o_init_start <= wr_cfg && (((next_cfg ^ cfg) & sdrcfg_pkg::CFG_INIT_MASK) != 32'h0000_0000);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= access;
            o_pslverr <= access & ~hit;
            o_prdata  <= 32'h0000_0000;
            if (access && !i_pwrite) begin
                if (i_paddr == sdrcfg_pkg::OFS_STATUS) begin
                    o_prdata[sdrcfg_pkg::BIT_DLL_READY] <= dll_ready;
                end else if (i_paddr == sdrcfg_pkg::OFS_CONFIG) begin
                    o_prdata <= cfg;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_cfg <= '0;
        end else begin
            o_cfg.bank_position_select       <= next_or_cfg(sdrcfg_pkg::BIT_BANK_POS);
            o_cfg.mobile_memory_enable       <= next_or_cfg(sdrcfg_pkg::BIT_MOBILE_EN);
            o_cfg.drive_strength             <= {next_or_cfg(sdrcfg_pkg::BIT_DRIVE_HI),
                                                 next_or_cfg(sdrcfg_pkg::BIT_DRIVE_LO)};
            o_cfg.differential_strobe_select <= next_or_cfg(sdrcfg_pkg::BIT_DIFF_STROBE);
            o_cfg.second_gen_enable          <= next_or_cfg(sdrcfg_pkg::BIT_DDR2_EN);
            o_cfg.double_rate_enable         <= next_or_cfg(sdrcfg_pkg::BIT_DDR_EN);
            o_cfg.sync_dram_enable           <= next_or_cfg(sdrcfg_pkg::BIT_SDRAM_EN);
            o_cfg.timing_write_unlock        <= next_or_cfg(sdrcfg_pkg::BIT_TIM_UNLOCK);
            o_cfg.narrow_bus_select          <= next_or_cfg(sdrcfg_pkg::BIT_NARROW);
            o_cfg.cas_latency                <= cfg_now[sdrcfg_pkg::POS_CAS +: 3];
            o_cfg.internal_bank_count        <= cfg_now[sdrcfg_pkg::POS_INTERNAL_BANK_COUNT +: 3];
            o_cfg.column_page_size           <= cfg_now[sdrcfg_pkg::POS_PAGE +: 3];
        end
    end

    // Reads the post-edge value so the exported fields never lag a write
    function automatic logic next_or_cfg(input int b);
        next_or_cfg = cfg_now[b];
    endfunction

endmodule
